// >>> src/adc_result_regs.svh
`ifndef ADC_RESULT_REGS_SVH
`define ADC_RESULT_REGS_SVH

// Byte addresses on the serial register port
`define CHAN_OFF_ADDR 8'h2C
`define IBUS_RES_ADDR 8'h2D
`define IBAT_RES_ADDR 8'h2F
`define VBUS_RES_ADDR 8'h31

// Reset values
`define CHAN_OFF_RESET 8'h00
`define RESULT_RESET 16'h0000

// Channel bit positions, also the converter channel codes
`define CH_INPUT_CURRENT 7
`define CH_BATTERY_CURRENT 6
`define CH_INPUT_VOLTAGE 5
`define CH_BATTERY_VOLTAGE 4
`define CH_SYSTEM_VOLTAGE 3
`define CH_THERMISTOR 2
`define CH_DIE_TEMPERATURE 1
`define CH_MID_NODE_VOLTAGE 0
`define CH_COUNT 8

// Result field placement and clamp codes, in steps of the field
`define IBUS_LSB 1
`define IBUS_WIDTH 15
`define IBUS_MIN (-2000)
`define IBUS_MAX 2000
`define IBAT_LSB 3
`define IBAT_WIDTH 13
`define IBAT_MIN (-2000)
`define IBAT_MAX 1005
`define VBUS_LSB 2
`define VBUS_WIDTH 13
`define VBUS_MIN 0
`define VBUS_MAX 4000

`endif

// >>> src/adc_result_pkg.sv
package adc_result_pkg;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_START = 2'b01,
		SEQ_WAIT = 2'b10,
		SEQ_DONE = 2'b11
	} seq_state_t;

	typedef logic signed [15:0] conv_code_t;

endpackage : adc_result_pkg

// >>> src/result_format.sv
`timescale 1ns/1ps
`include "adc_result_regs.svh"

module result_format #(
	parameter int LSB = 1,
	parameter int WIDTH = 15,
	parameter int MIN = -2000,
	parameter int MAX = 2000
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Conversion in
	input wire logic load,
	input wire adc_result_pkg::conv_code_t code,
	// Register value
	output logic [15:0] result_q
);

	localparam logic signed [15:0] LO = 16'(MIN);
	localparam logic signed [15:0] HI = 16'(MAX);

	logic signed [15:0] clamped;
	logic [15:0] result_d;

	always_comb
	begin
		if (code < LO)
			clamped = LO;
		else if (code > HI)
			clamped = HI;
		else
			clamped = code;
		result_d = result_q;
		if (load)
		begin
			// Unused positions stay zero
			result_d = `RESULT_RESET;
			result_d[LSB +: WIDTH] = clamped[WIDTH-1:0];
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			result_q <= `RESULT_RESET;
		else
			result_q <= result_d;
	end

	a_field_range: assert property (@(posedge ref_clk) disable iff (rst)
		load |=> $signed(result_q[LSB +: WIDTH]) >= MIN
			&& $signed(result_q[LSB +: WIDTH]) <= MAX)
		else $error("result outside clamp range");

	a_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
		(result_q & ~(((16'h0001 << WIDTH) - 16'h0001) << LSB)) == 16'h0000)
		else $error("reserved result bit set");

endmodule : result_format

// >>> src/adc_channel_result_regs.sv
`timescale 1ns/1ps
`include "adc_result_regs.svh"

// Summary of operation
// - Channel-off bits, 7 input current down to 0 mid node voltage; 1 skips a channel.
// - The channel-off register is read-write and clears to zero on reset and on register reset.
// - Input current sits in bits 15:1 as two's complement, positive from input bus to mid node.
// - Input current uses 2.5 mA steps and clamps between codes 7830h and 7D0h.
// - Battery current sits in bits 15:3 as two's complement, 5 mA steps, positive on charge.
// - Battery current clamps between codes 1830h and 3EDh.
// - Input voltage sits unsigned in bits 14:2, 5 mV steps, clamped high at FA0h.
// - Each result register is 16 bits, read-only, and zero after reset until a conversion.
// - Conversions loop over enabled channels in continuous mode and make one pass in one-shot.
module adc_channel_result_regs (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic soft_reg_reset,
	// Byte register port from the serial engine
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Converter control
	input wire logic conv_run,
	input wire logic single_pass,
	output logic conv_start,
	output logic [2:0] conv_sel,
	output logic pass_done,
	// Converter results
	input wire logic conv_valid,
	input wire adc_result_pkg::conv_code_t conv_code,
	// Channel gates
	output logic [7:0] channel_off
);

	adc_result_pkg::seq_state_t state_q, state_d;
	logic [2:0] sel_q, sel_d;
	logic [7:0] chan_off_q, chan_off_d;
	logic [7:0] rdata_q, rdata_d;
	logic [3:0] pick;
	logic [3:0] first;
	logic chan_wr;
	logic [15:0] ibus_q, ibat_q, vbus_q;
	logic ibus_load, ibat_load, vbus_load;

	// Highest enabled channel below limit; bit 3 flags a hit
	function automatic logic [3:0] next_chan(input logic [7:0] off, input logic [3:0] limit);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < `CH_COUNT; i++)
		begin
			if (4'(i) < limit && !off[i])
				r = {1'b1, 3'(i)};
		end
		return r;
	endfunction : next_chan

	assign chan_wr = reg_wr && reg_addr == `CHAN_OFF_ADDR;
	assign channel_off = chan_off_q;
	assign conv_start = state_q == adc_result_pkg::SEQ_START;
	assign conv_sel = sel_q;
	assign reg_rdata = rdata_q;

	// Register file
	always_comb
	begin
		chan_off_d = chan_off_q;
		if (soft_reg_reset)
			chan_off_d = `CHAN_OFF_RESET;
		else if (chan_wr)
			chan_off_d = reg_wdata;
		rdata_d = rdata_q;
		if (reg_rd)
		begin
			// Unmapped read addresses fall through to the default and return zero
			unique case (reg_addr)
				`CHAN_OFF_ADDR: rdata_d = chan_off_q;
				`IBUS_RES_ADDR: rdata_d = ibus_q[7:0];
				`IBUS_RES_ADDR + 8'h01: rdata_d = ibus_q[15:8];
				`IBAT_RES_ADDR: rdata_d = ibat_q[7:0];
				`IBAT_RES_ADDR + 8'h01: rdata_d = ibat_q[15:8];
				`VBUS_RES_ADDR: rdata_d = vbus_q[7:0];
				`VBUS_RES_ADDR + 8'h01: rdata_d = vbus_q[15:8];
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			chan_off_q <= `CHAN_OFF_RESET;
			rdata_q <= 8'h00;
		end
		else
		begin
			chan_off_q <= chan_off_d;
			rdata_q <= rdata_d;
		end
	end

	// Conversion sequencer
	always_comb
	begin
		state_d = state_q;
		sel_d = sel_q;
		pass_done = 1'b0;
		pick = next_chan(chan_off_q,
			(state_q == adc_result_pkg::SEQ_WAIT) ? {1'b0, sel_q} : 4'h8);
		first = next_chan(chan_off_q, 4'h8);
		unique case (state_q)
			adc_result_pkg::SEQ_IDLE:
			begin
				if (conv_run && pick[3])
				begin
					state_d = adc_result_pkg::SEQ_START;
					sel_d = pick[2:0];
				end
			end
			adc_result_pkg::SEQ_START:
				state_d = adc_result_pkg::SEQ_WAIT;
			adc_result_pkg::SEQ_WAIT:
			begin
				if (conv_valid)
				begin
					if (pick[3])
					begin
						state_d = adc_result_pkg::SEQ_START;
						sel_d = pick[2:0];
					end
					else
					begin
						pass_done = 1'b1;
						if (single_pass)
							state_d = adc_result_pkg::SEQ_DONE;
						else if (first[3])
						begin
							state_d = adc_result_pkg::SEQ_START;
							sel_d = first[2:0];
						end
						else
							state_d = adc_result_pkg::SEQ_IDLE;
					end
				end
			end
			adc_result_pkg::SEQ_DONE:
				state_d = adc_result_pkg::SEQ_DONE;
		endcase
		// Dropping run aborts a conversion; a late result is then discarded
		if (!conv_run)
			state_d = adc_result_pkg::SEQ_IDLE;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_q <= adc_result_pkg::SEQ_IDLE;
			sel_q <= 3'h0;
		end
		else
		begin
			state_q <= state_d;
			sel_q <= sel_d;
		end
	end

	// Result capture
	assign ibus_load = conv_valid && state_q == adc_result_pkg::SEQ_WAIT
		&& sel_q == 3'(`CH_INPUT_CURRENT);
	assign ibat_load = conv_valid && state_q == adc_result_pkg::SEQ_WAIT
		&& sel_q == 3'(`CH_BATTERY_CURRENT);
	assign vbus_load = conv_valid && state_q == adc_result_pkg::SEQ_WAIT
		&& sel_q == 3'(`CH_INPUT_VOLTAGE);

	result_format #(.LSB(`IBUS_LSB), .WIDTH(`IBUS_WIDTH), .MIN(`IBUS_MIN), .MAX(`IBUS_MAX))
	u_ibus (
		.ref_clk(ref_clk),
		.rst(rst),
		.load(ibus_load),
		.code(conv_code),
		.result_q(ibus_q)
	);

	result_format #(.LSB(`IBAT_LSB), .WIDTH(`IBAT_WIDTH), .MIN(`IBAT_MIN), .MAX(`IBAT_MAX))
	u_ibat (
		.ref_clk(ref_clk),
		.rst(rst),
		.load(ibat_load),
		.code(conv_code),
		.result_q(ibat_q)
	);

	result_format #(.LSB(`VBUS_LSB), .WIDTH(`VBUS_WIDTH), .MIN(`VBUS_MIN), .MAX(`VBUS_MAX))
	u_vbus (
		.ref_clk(ref_clk),
		.rst(rst),
		.load(vbus_load),
		.code(conv_code),
		.result_q(vbus_q)
	);

	sequence s_final;
		pass_done && single_pass && conv_run;
	endsequence

	sequence s_run_on;
		conv_run [*2];
	endsequence

	a_start_enabled: assert property (@(posedge ref_clk) disable iff (rst)
		conv_start && !$past(chan_wr) && !$past(soft_reg_reset) |-> !chan_off_q[conv_sel])
		else $error("disabled channel started");

	a_chan_soft_reset: assert property (@(posedge ref_clk) disable iff (rst)
		soft_reg_reset |=> chan_off_q == 8'h00)
		else $error("register reset left channel bits set");

	a_chan_write: assert property (@(posedge ref_clk) disable iff (rst)
		chan_wr && !soft_reg_reset |=> chan_off_q == $past(reg_wdata))
		else $error("channel register write lost");

	a_ibus_place: assert property (@(posedge ref_clk) disable iff (rst)
		ibus_load && conv_code >= -16'sd2000 && conv_code <= 16'sd2000
		|=> ibus_q == {$past(conv_code[14:0]), 1'b0})
		else $error("input current misplaced");

	a_ibus_clamp_low: assert property (@(posedge ref_clk) disable iff (rst)
		ibus_load && conv_code < -16'sd2000 |=> ibus_q == 16'hF060)
		else $error("input current low clamp wrong");

	a_ibat_clamp_high: assert property (@(posedge ref_clk) disable iff (rst)
		ibat_load && conv_code > 16'sd1005 |=> ibat_q[15:3] == 13'h03ED)
		else $error("battery current high clamp wrong");

	a_ibat_place: assert property (@(posedge ref_clk) disable iff (rst)
		ibat_load && conv_code >= -16'sd2000 && conv_code <= 16'sd1005
		|=> ibat_q == {$past(conv_code[12:0]), 3'h0})
		else $error("battery current misplaced");

	a_vbus_clamp: assert property (@(posedge ref_clk) disable iff (rst)
		vbus_load && conv_code > 16'sd4000 |=> vbus_q == 16'h3E80)
		else $error("input voltage clamp wrong");

	a_result_write_ignored: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr && !conv_valid |=> $stable(ibus_q) && $stable(ibat_q) && $stable(vbus_q))
		else $error("result changed without conversion");

	a_result_after_reset: assert property (@(posedge ref_clk)
		rst |=> ibus_q == 16'h0000 && ibat_q == 16'h0000 && vbus_q == 16'h0000)
		else $error("result not zero after reset");

	a_single_pass_stop: assert property (@(posedge ref_clk) disable iff (rst)
		s_final ##1 s_run_on |-> state_q == adc_result_pkg::SEQ_DONE && !conv_start)
		else $error("one-shot pass restarted");

	a_continuous_loop: assert property (@(posedge ref_clk) disable iff (rst)
		pass_done && !single_pass && conv_run && chan_off_q != 8'hFF |=> conv_start)
		else $error("continuous mode did not restart");

endmodule : adc_channel_result_regs

// >>> verif/conv_model.sv
`timescale 1ns/1ps

// Converter stand-in; code line scrambles outside the valid cycle
module conv_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Request
	input wire logic conv_start,
	input wire logic [2:0] conv_sel,
	input wire logic [3:0] delay,
	input wire adc_result_pkg::conv_code_t codes [8],
	// Answer
	output logic conv_valid,
	output adc_result_pkg::conv_code_t conv_code
);
	logic [2:0] sel;
	logic [4:0] cnt;

	always @(posedge ref_clk)
	begin
		conv_valid <= 1'b0;
		conv_code <= ~conv_code;
		if (rst)
		begin
			cnt <= 5'h00;
			conv_code <= 16'sh0000;
		end
		else if (conv_start)
		begin
			sel <= conv_sel;
			cnt <= {1'b0, delay} + 5'h01;
		end
		else if (cnt == 5'h01)
		begin
			conv_valid <= 1'b1;
			conv_code <= codes[sel];
			cnt <= 5'h00;
		end
		else if (cnt != 5'h00)
			cnt <= cnt - 5'h01;
	end
endmodule : conv_model

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`include "adc_result_regs.svh"

module tb_top;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic soft_reg_reset = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic conv_run = 1'b0;
	logic single_pass = 1'b1;
	logic conv_start, pass_done, conv_valid;
	logic [2:0] conv_sel;
	logic [7:0] channel_off;
	logic [3:0] delay = 4'h0;
	adc_result_pkg::conv_code_t conv_code;
	adc_result_pkg::conv_code_t codes [8] = '{default: 16'sh0000};
	logic [2:0] seq [$];
	int fail_count = 0;
	int n_tests = 0;
	int cyc = 0;

	adc_channel_result_regs u_adc_channel_result_regs (.ref_clk, .rst, .soft_reg_reset,
		.reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .conv_run, .single_pass,
		.conv_start, .conv_sel, .pass_done, .conv_valid, .conv_code, .channel_off);
	conv_model u_conv_model (.ref_clk, .rst, .conv_start, .conv_sel, .delay, .codes,
		.conv_valid, .conv_code);

	initial
	begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		if (conv_start === 1'b1)
			seq.push_back(conv_sel);
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [15:0] v, input logic [15:0] e, input string m);
		n_tests++;
		if (v !== e)
		begin
			fail_count++;
			$display("wrong value %0t %s got %h exp %h", $time, m, v, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data holds until the next strobe, so sampling late is safe
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		v = {8'h00, reg_rdata};
	endtask : rd

	task automatic rd16(input logic [7:0] a, output logic [15:0] v);
		logic [15:0] lo;
		logic [15:0] hi;
		rd(a, lo);
		rd(a + 8'h01, hi);
		v = {hi[7:0], lo[7:0]};
	endtask : rd16

	function automatic logic [15:0] fmt(int c, int s, int lo, int hi);
		int k;
		k = c < lo ? lo : (c > hi ? hi : c);
		return 16'(k <<< s);
	endfunction : fmt

	task automatic t_reset();
		logic [15:0] v;
		for (int a = 8'h2B; a <= 8'h33; a++)
		begin
			rd(8'(a), v);
			chk(v, 16'h0000, "reset");
		end
		$display("test reset done");
	endtask : t_reset

	task automatic t_regs();
		logic [15:0] v;
		wr(`CHAN_OFF_ADDR, 8'hA5);
		rd(`CHAN_OFF_ADDR, v);
		chk(v, 16'h00A5, "off rd");
		chk({8'h00, channel_off}, 16'h00A5, "off port");
		for (int a = 8'h2D; a <= 8'h32; a++)
		begin
			wr(8'(a), 8'hFF);
			rd(8'(a), v);
			chk(v, 16'h0000, "ro");
		end
		@(posedge ref_clk);
		soft_reg_reset <= 1'b1;
		@(posedge ref_clk);
		soft_reg_reset <= 1'b0;
		rd(`CHAN_OFF_ADDR, v);
		chk(v, 16'h0000, "soft");
		$display("test regs done");
	endtask : t_regs

	// Skipped channel keeps its old result, so expected codes come apart
	task automatic conv(input int ic, input int bc, input int vc, input logic [7:0] off,
		input logic sp, input int np, input logic [3:0] dl, input int eb);
		int k;
		logic [2:0] e [$];
		logic [15:0] v;
		codes[`CH_INPUT_CURRENT] <= 16'(ic);
		codes[`CH_BATTERY_CURRENT] <= 16'(bc);
		codes[`CH_INPUT_VOLTAGE] <= 16'(vc);
		delay <= dl;
		wr(`CHAN_OFF_ADDR, off);
		seq.delete();
		single_pass <= sp;
		conv_run <= 1'b1;
		k = 0;
		for (int i = 0; i < 400 && k < np; i++)
		begin
			@(posedge ref_clk);
			if (pass_done === 1'b1)
				k++;
		end
		// One-shot keeps run up a while to show it stays stopped
		if (sp)
			repeat (3) @(posedge ref_clk);
		conv_run <= 1'b0;
		for (int p = 0; p < np; p++)
			for (int c = 7; c >= 0; c--)
				if (!off[c])
					e.push_back(3'(c));
		if (!sp)
			e.push_back(e[0]);
		// Last start is logged at the next edge; wait past it to avoid a race
		repeat (2) @(posedge ref_clk);
		chk(16'(seq.size()), 16'(e.size()), "starts");
		foreach (e[i]) chk({13'h0, seq[i]}, {13'h0, e[i]}, "order");
		rd16(`IBUS_RES_ADDR, v);
		chk(v, fmt(ic, `IBUS_LSB, `IBUS_MIN, `IBUS_MAX), "in cur");
		rd16(`IBAT_RES_ADDR, v);
		chk(v, fmt(eb, `IBAT_LSB, `IBAT_MIN, `IBAT_MAX), "bat cur");
		rd16(`VBUS_RES_ADDR, v);
		chk(v, fmt(vc, `VBUS_LSB, `VBUS_MIN, `VBUS_MAX), "in volt");
		$display("test conv done");
	endtask : conv

	initial
	begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_regs();
		conv(3000, -3000, 5000, 8'h00, 1'b1, 1, 4'h0, -3000);
		conv(-2500, 1100, -1, 8'h00, 1'b1, 1, 4'h5, 1100);
		conv(-5, 7, 4000, 8'h40, 1'b0, 2, 4'h1, 1100);
		stop_test();
	end
endmodule : tb_top
